/* File: rtl/sgpef_map.vh */
/*
 * Register map and field layout of the shared port E/F block.
 * Assumes word-aligned AHB-Lite access; byte address = index * 4.
 */
`ifndef SGPEF_MAP_VH
`define SGPEF_MAP_VH

// Register indices; the byte address is the index shifted left by two
`define SGPEF_IDX_E_DATA   6'h08
`define SGPEF_IDX_F_DATA   6'h09
`define SGPEF_IDX_E_DIR    6'h0c
`define SGPEF_IDX_F_DIR    6'h0d
`define SGPEF_IDX_ROUTE    6'h10
`define SGPEF_IDX_TMR_ELS  6'h11

// Fields of the peripheral routing register
`define SGPEF_RT_SPI_EN    0
`define SGPEF_RT_SPI_MSTR  1
`define SGPEF_RT_MODF_EN   2
`define SGPEF_RT_SCI_EN    3

// Port E pin positions of the shared functions
`define SGPEF_E_SCK        7
`define SGPEF_E_MOSI       6
`define SGPEF_E_MISO       5
`define SGPEF_E_SS         4
`define SGPEF_E_TCH1       3
`define SGPEF_E_TCH0       2
`define SGPEF_E_RXD        1
`define SGPEF_E_TXD        0

// Reset values
`define SGPEF_RST_E_DATA   8'h00
`define SGPEF_RST_E_DIR    8'h00
`define SGPEF_RST_F_DIR    4'h0
`define SGPEF_RST_ROUTE    4'h0
`define SGPEF_RST_TMR_ELS  12'h000

`endif

/* File: rtl/sgpef_pin_mux.v */
/*
 * Output stage of a group of port pins: picks latch/direction or the
 * owning peripheral's drive and registers the pin value and enable.
 * Assumes a synchronous active-high reset and one clock.
 */
`timescale 1ns/100ps

module sgpef_pin_mux #(
    parameter WIDTH = 8
) (
    input  wire             clk_in,     // Block clock
    input  wire             rst_in,     // Synchronous reset
    input  wire [WIDTH-1:0] latch_in,   // Port data latch
    input  wire [WIDTH-1:0] dir_in,     // Direction bits, 1 = output
    input  wire [WIDTH-1:0] own_in,     // Pin owned by a peripheral
    input  wire [WIDTH-1:0] per_val_in, // Peripheral drive value
    input  wire [WIDTH-1:0] per_oe_in,  // Peripheral output enable
    output reg  [WIDTH-1:0] pin_out,    // Registered pin value
    output reg  [WIDTH-1:0] pin_oe_out  // Registered pin enable
);

    wire [WIDTH-1:0] val_next; // Pin value for the next edge
    wire [WIDTH-1:0] oe_next;  // Pin enable for the next edge

    genvar i;

    // An owned pin follows its peripheral, any other its latch and direction
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            assign val_next[i] = own_in[i] ? per_val_in[i] : latch_in[i]; // [RULE_19]
            assign oe_next[i]  = own_in[i] ? per_oe_in[i] : dir_in[i]; // [RULE_09] [RULE_17]
        end
    endgenerate

    // One flop pair per pin keeps the pad free of combinational glitches
    always @(posedge clk_in) begin
        if (rst_in) begin
            pin_out    <= {WIDTH{1'b0}};
            pin_oe_out <= {WIDTH{1'b0}};
        end else begin
            pin_out    <= val_next;
            pin_oe_out <= oe_next; // [RULE_02] [RULE_14]
        end
    end

endmodule // sgpef_pin_mux

/* File: rtl/sgpef_top.v */
/*
 * Shared general-purpose ports E (8 pins) and F (4 pins) with an
 * AHB-Lite register slave and hand-over of pins to SPI, serial and
 * timer peripherals.
 * Assumes pins and peripheral drives are synchronous to REF_CLK_IN,
 * and a single AHB-Lite master doing whole-word single transfers.
 */
//
// Summary of operation
// RULE_01: Port E has eight read/write latch bits, each with a direction bit.
// RULE_02: Port E direction one drives the pin; reset clears all direction bits.
// RULE_03: Port E read gives latch where direction is one, pin level otherwise.
// RULE_04: Data latches take writes in any direction; input pins unaffected.
// RULE_05: With SPI enabled, E7 is SPI clock, output as master, input as slave.
// RULE_06: With SPI enabled, E6 is master-out/slave-in, else plain I/O.
// RULE_07: With SPI enabled, E5 is master-in/slave-out, else plain I/O.
// RULE_08: E4 is slave select unless SPI off or master without mode-fault check.
// RULE_09: Peripheral-owned E pins ignore direction for driving, not for reads.
// RULE_10: E3 and E2 become timer channels 1 and 0 when selected.
// RULE_11: With serial interface enabled, E1 is its receive input.
// RULE_12: With serial interface enabled, E0 is its transmit output.
// RULE_13: Port F has four latch bits with direction bits; reset keeps latches.
// RULE_14: Port F direction one drives the pin; reset clears direction bits.
// RULE_15: Port F read gives latch where direction is one, pin level otherwise.
// RULE_16: F3 to F0 become timer channels 5 to 2 when selected.
// RULE_17: Timer-owned F pins ignore direction for driving, not for reads.
// RULE_18: Software should load the latch before turning a pin to output.
// RULE_19: An owned pin takes value and enable from its peripheral.
`timescale 1ns/100ps
`include "sgpef_map.vh"

module sgpef_top #(
    parameter E_WIDTH = 8,
    parameter F_WIDTH = 4,
    parameter T_CHANS = 6
) (
    input  wire                 REF_CLK_IN,      // 20 MHz block clock
    input  wire                 RST_IN,          // Synchronous reset, high
    input  wire                 HSEL_IN,         // AHB slave select
    input  wire [7:0]           HADDR_IN,        // AHB byte address
    input  wire [1:0]           HTRANS_IN,       // AHB transfer type
    input  wire                 HWRITE_IN,       // AHB write, high
    input  wire [2:0]           HSIZE_IN,        // AHB size, word only
    input  wire [31:0]          HWDATA_IN,       // AHB write data
    input  wire                 HREADY_IN,       // AHB bus ready
    output reg  [31:0]          HRDATA_OUT,      // AHB read data
    output reg                  HREADYOUT_OUT,   // AHB slave ready
    output reg                  HRESP_OUT,       // AHB response, always OKAY
    input  wire [E_WIDTH-1:0]   PE_PIN_IN,       // Port E pin levels
    output wire [E_WIDTH-1:0]   PE_PIN_OUT,      // Port E pin drive value
    output wire [E_WIDTH-1:0]   PE_PIN_OE_OUT,   // Port E pin drive enable
    input  wire [F_WIDTH-1:0]   PF_PIN_IN,       // Port F pin levels
    output wire [F_WIDTH-1:0]   PF_PIN_OUT,      // Port F pin drive value
    output wire [F_WIDTH-1:0]   PF_PIN_OE_OUT,   // Port F pin drive enable
    input  wire                 SPI_SCK_DRV_IN,  // SPI master clock drive
    input  wire                 SPI_MOSI_DRV_IN, // SPI master data drive
    input  wire                 SPI_MISO_DRV_IN, // SPI slave data drive
    input  wire                 SCI_TXD_DRV_IN,  // Serial transmit drive
    input  wire [T_CHANS-1:0]   TMR_CH_DRV_IN,   // Timer channel drives
    input  wire [T_CHANS-1:0]   TMR_CH_OE_IN,    // Timer channel enables
    output reg                  SPI_ENABLE_OUT,  // SPI enable bit
    output reg                  SPI_MASTER_OUT,  // SPI master select
    output reg                  MODE_FAULT_EN_OUT, // SPI mode-fault enable
    output reg                  SCI_ENABLE_OUT,  // Serial interface enable
    output reg  [2*T_CHANS-1:0] TMR_ELS_OUT      // Timer edge/level selects
);

    // Byte-lane-free read of a port: latch where output, pin where input
    function [7:0] port_read;
        input [7:0] latch;
        input [7:0] dir;
        input [7:0] pin;
        begin
            port_read = (latch & dir) | (pin & ~dir);
        end
    endfunction

    // A timer channel claims its pin for any non-zero edge/level select
    function chan_on;
        input [1:0] els;
        begin
            chan_on = els[1] | els[0];
        end
    endfunction

    // Register state and next values
    reg  [E_WIDTH-1:0]   e_latch_reg;
    reg  [E_WIDTH-1:0]   e_latch_next;
    reg  [E_WIDTH-1:0]   e_dir_reg;
    reg  [E_WIDTH-1:0]   e_dir_next;
    reg  [F_WIDTH-1:0]   f_latch_reg;
    reg  [F_WIDTH-1:0]   f_latch_next;
    reg  [F_WIDTH-1:0]   f_dir_reg;
    reg  [F_WIDTH-1:0]   f_dir_next;
    reg  [3:0]           route_reg;
    reg  [3:0]           route_next;
    reg  [2*T_CHANS-1:0] els_reg;
    reg  [2*T_CHANS-1:0] els_next;

    // Bus pipeline state
    reg                  wr_pend_reg;
    reg  [5:0]           wr_idx_reg;
    reg  [31:0]          rdata_next;

    // Pin ownership and peripheral drives
    reg  [E_WIDTH-1:0]   e_own;
    reg  [E_WIDTH-1:0]   e_per_val;
    reg  [E_WIDTH-1:0]   e_per_oe;
    wire [F_WIDTH-1:0]   f_own;
    wire [T_CHANS-1:0]   chan_sel;

    wire                 addr_ok;
    wire [5:0]           addr_idx;
    wire                 spi_en;
    wire                 spi_mstr;
    wire                 modf_en;
    wire                 sci_en;

    assign addr_ok  = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
    assign addr_idx = HADDR_IN[7:2];
    assign spi_en   = route_reg[`SGPEF_RT_SPI_EN];
    assign spi_mstr = route_reg[`SGPEF_RT_SPI_MSTR];
    assign modf_en  = route_reg[`SGPEF_RT_MODF_EN];
    assign sci_en   = route_reg[`SGPEF_RT_SCI_EN];

    // Address phase capture; writes land in the following data phase
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 6'h00;
        end else begin
            wr_pend_reg <= addr_ok & HWRITE_IN;
            wr_idx_reg  <= addr_idx;
        end
    end

    // Write decode; unmapped indices are ignored and still answer OKAY
    always @* begin
        e_latch_next = e_latch_reg;
        e_dir_next   = e_dir_reg;
        f_latch_next = f_latch_reg;
        f_dir_next   = f_dir_reg;
        route_next   = route_reg;
        els_next     = els_reg;
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                `SGPEF_IDX_E_DATA: begin
                    e_latch_next = HWDATA_IN[E_WIDTH-1:0]; // [RULE_01] [RULE_04]
                end
                `SGPEF_IDX_F_DATA: begin
                    f_latch_next = HWDATA_IN[F_WIDTH-1:0]; // [RULE_13] [RULE_04]
                end
                `SGPEF_IDX_E_DIR: begin
                    e_dir_next = HWDATA_IN[E_WIDTH-1:0];   // [RULE_01]
                end
                `SGPEF_IDX_F_DIR: begin
                    f_dir_next = HWDATA_IN[F_WIDTH-1:0];   // [RULE_13]
                end
                `SGPEF_IDX_ROUTE: begin
                    route_next = HWDATA_IN[3:0];
                end
                `SGPEF_IDX_TMR_ELS: begin
                    els_next = HWDATA_IN[2*T_CHANS-1:0];
                end
                default: begin
                    route_next = route_reg;
                end
            endcase
        end
    end

    // Control registers; direction bits clear so every pin starts as input
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            e_latch_reg <= `SGPEF_RST_E_DATA;
            e_dir_reg   <= `SGPEF_RST_E_DIR;  // [RULE_02]
            f_dir_reg   <= `SGPEF_RST_F_DIR;  // [RULE_14]
            route_reg   <= `SGPEF_RST_ROUTE;
            els_reg     <= `SGPEF_RST_TMR_ELS;
        end else begin
            e_latch_reg <= e_latch_next;
            e_dir_reg   <= e_dir_next;
            f_dir_reg   <= f_dir_next;
            route_reg   <= route_next;
            els_reg     <= els_next;
        end
    end

    // Port F latch is deliberately outside reset, so it survives a reset
    always @(posedge REF_CLK_IN) begin
        f_latch_reg <= f_latch_next; // [RULE_13]
    end

    // Read data from next values, so a read right after a write sees it
    always @* begin
        rdata_next = 32'h0000_0000;
        case (addr_idx)
            `SGPEF_IDX_E_DATA: begin
                rdata_next[7:0] = port_read(e_latch_next, e_dir_next,
                                            PE_PIN_IN); // [RULE_03] [RULE_09]
            end
            `SGPEF_IDX_F_DATA: begin
                rdata_next[7:0] = port_read({4'h0, f_latch_next},
                                            {4'h0, f_dir_next},
                                            {4'h0, PF_PIN_IN}); // [RULE_15] [RULE_17]
            end
            `SGPEF_IDX_E_DIR: begin
                rdata_next[E_WIDTH-1:0] = e_dir_next;
            end
            `SGPEF_IDX_F_DIR: begin
                rdata_next[F_WIDTH-1:0] = f_dir_next;
            end
            `SGPEF_IDX_ROUTE: begin
                rdata_next[3:0] = route_next;
            end
            `SGPEF_IDX_TMR_ELS: begin
                rdata_next[2*T_CHANS-1:0] = els_next;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Zero-wait slave: data is ready in the first data-phase cycle
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            HRDATA_OUT    <= 32'h0000_0000;
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
        end else begin
            HREADYOUT_OUT <= 1'b1;
            HRESP_OUT     <= 1'b0;
            if (addr_ok && !HWRITE_IN) begin
                HRDATA_OUT <= rdata_next;
            end else begin
                HRDATA_OUT <= 32'h0000_0000;
            end
        end
    end

    // Enables handed to the peripherals straight from flops
    always @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            SPI_ENABLE_OUT    <= 1'b0;
            SPI_MASTER_OUT    <= 1'b0;
            MODE_FAULT_EN_OUT <= 1'b0;
            SCI_ENABLE_OUT    <= 1'b0;
            TMR_ELS_OUT       <= `SGPEF_RST_TMR_ELS;
        end else begin
            SPI_ENABLE_OUT    <= route_next[`SGPEF_RT_SPI_EN];
            SPI_MASTER_OUT    <= route_next[`SGPEF_RT_SPI_MSTR];
            MODE_FAULT_EN_OUT <= route_next[`SGPEF_RT_MODF_EN];
            SCI_ENABLE_OUT    <= route_next[`SGPEF_RT_SCI_EN];
            TMR_ELS_OUT       <= els_next;
        end
    end

    // Channel select per timer channel
    genvar c;
    generate
        for (c = 0; c < T_CHANS; c = c + 1) begin : g_chan
            assign chan_sel[c] = chan_on(els_reg[2*c+1:2*c]);
        end
    endgenerate

    // Port F pins map to timer channels 2 upward
    generate
        for (c = 0; c < F_WIDTH; c = c + 1) begin : g_f_own
            assign f_own[c] = chan_sel[c+2]; // [RULE_16]
        end
    endgenerate

    // Port E ownership and drives; slave-select and receive never drive
    always @* begin
        e_own     = {E_WIDTH{1'b0}};
        e_per_val = {E_WIDTH{1'b0}};
        e_per_oe  = {E_WIDTH{1'b0}};

        // SPI clock: out as master, in as slave
        e_own[`SGPEF_E_SCK]     = spi_en;               // [RULE_05]
        e_per_val[`SGPEF_E_SCK] = SPI_SCK_DRV_IN;
        e_per_oe[`SGPEF_E_SCK]  = spi_mstr;             // [RULE_05]

        // Master-out line driven only by a master
        e_own[`SGPEF_E_MOSI]     = spi_en;              // [RULE_06]
        e_per_val[`SGPEF_E_MOSI] = SPI_MOSI_DRV_IN;
        e_per_oe[`SGPEF_E_MOSI]  = spi_mstr;

        // Master-in line driven only by a slave
        e_own[`SGPEF_E_MISO]     = spi_en;              // [RULE_07]
        e_per_val[`SGPEF_E_MISO] = SPI_MISO_DRV_IN;
        e_per_oe[`SGPEF_E_MISO]  = ~spi_mstr;

        // Slave select is freed when a master ignores mode faults
        e_own[`SGPEF_E_SS] = spi_en & ~(spi_mstr & ~modf_en); // [RULE_08]

        // Timer channels 1 and 0
        e_own[`SGPEF_E_TCH1]     = chan_sel[1];         // [RULE_10]
        e_per_val[`SGPEF_E_TCH1] = TMR_CH_DRV_IN[1];
        e_per_oe[`SGPEF_E_TCH1]  = TMR_CH_OE_IN[1];
        e_own[`SGPEF_E_TCH0]     = chan_sel[0];         // [RULE_10]
        e_per_val[`SGPEF_E_TCH0] = TMR_CH_DRV_IN[0];
        e_per_oe[`SGPEF_E_TCH0]  = TMR_CH_OE_IN[0];

        // Serial receive input and transmit output
        e_own[`SGPEF_E_RXD]     = sci_en;               // [RULE_11]
        e_own[`SGPEF_E_TXD]     = sci_en;               // [RULE_12]
        e_per_val[`SGPEF_E_TXD] = SCI_TXD_DRV_IN;
        e_per_oe[`SGPEF_E_TXD]  = 1'b1;                 // [RULE_12]
    end

    // Port E output stage
    sgpef_pin_mux #(
        .WIDTH (E_WIDTH)
    ) u_e_mux (
        .clk_in     (REF_CLK_IN),
        .rst_in     (RST_IN),
        .latch_in   (e_latch_reg),
        .dir_in     (e_dir_reg),
        .own_in     (e_own),
        .per_val_in (e_per_val),
        .per_oe_in  (e_per_oe),
        .pin_out    (PE_PIN_OUT),
        .pin_oe_out (PE_PIN_OE_OUT)
    );

    // Port F output stage; timer drives fill in the owned pins
    sgpef_pin_mux #(
        .WIDTH (F_WIDTH)
    ) u_f_mux (
        .clk_in     (REF_CLK_IN),
        .rst_in     (RST_IN),
        .latch_in   (f_latch_reg),
        .dir_in     (f_dir_reg),
        .own_in     (f_own),
        .per_val_in (TMR_CH_DRV_IN[T_CHANS-1:2]),
        .per_oe_in  (TMR_CH_OE_IN[T_CHANS-1:2]),
        .pin_out    (PF_PIN_OUT),
        .pin_oe_out (PF_PIN_OE_OUT)
    );

endmodule // sgpef_top

/* File: dv/sgpef_pins.sv */
/*
 * Pin model for one port: external circuitry that yields wherever the block
 * drives a pin. Assumes it shares the block clock.
 */
`timescale 1ns/100ps

module sgpef_pins #(
    parameter W = 8
) (
    input  wire logic [W-1:0] clk_in,    // Block clock (bit 0 used)
    input  wire logic [W-1:0] pin_in,    // Block drive value
    input  wire logic [W-1:0] oe_in,     // Block drive enable
    input  wire logic [W-1:0] ext_in,    // External drive value
    input  wire logic [W-1:0] ext_en_in, // External drive enable
    output logic      [W-1:0] level_out  // Resolved pin level
);
    logic [W-1:0] float_reg = '0;

    // A floating line wanders every cycle, so a stale level never reads as valid
    always @(posedge clk_in[0]) begin
        float_reg <= ~float_reg;
    end

    // Block drive wins, then the external driver, else the line floats
    assign level_out = (oe_in & pin_in) | (~oe_in & ext_en_in & ext_in)
                     | (~oe_in & ~ext_en_in & float_reg);
endmodule // sgpef_pins

/* File: dv/sgpef_checker.sv */
/*
 * Assertions on pin hand-over and read data of the port E/F block.
 * Sees only the top module's ports; bound to sgpef_top below.
 */
`timescale 1ns/100ps

module sgpef_checker #(
    parameter E_WIDTH = 8,
    parameter F_WIDTH = 4,
    parameter T_CHANS = 6
) (
    input wire logic REF_CLK_IN, RST_IN, HSEL_IN, HWRITE_IN, HREADY_IN, // Clock, reset, bus
    input wire logic [1:0]           HTRANS_IN,  // Transfer type
    input wire logic [31:0]          HRDATA_OUT, // Read data
    input wire logic [E_WIDTH-1:0]   PE_PIN_OUT, PE_PIN_OE_OUT, // Port E drive
    input wire logic [F_WIDTH-1:0]   PF_PIN_OUT, PF_PIN_OE_OUT, // Port F drive
    input wire logic SPI_SCK_DRV_IN, SPI_MOSI_DRV_IN, SPI_MISO_DRV_IN, // SPI drives
    input wire logic SCI_TXD_DRV_IN, SPI_ENABLE_OUT, SPI_MASTER_OUT,   // Serial, routing
    input wire logic MODE_FAULT_EN_OUT, SCI_ENABLE_OUT,                // Routing
    input wire logic [T_CHANS-1:0]   TMR_CH_DRV_IN, TMR_CH_OE_IN,  // Timer drives
    input wire logic [2*T_CHANS-1:0] TMR_ELS_OUT  // Timer selects
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    // Pin drive lags the routing register by one edge
    sequence s_mst; SPI_ENABLE_OUT && SPI_MASTER_OUT; endsequence
    sequence s_slv; SPI_ENABLE_OUT && !SPI_MASTER_OUT; endsequence

    property p_sck_m; s_mst |=> PE_PIN_OE_OUT[7] && PE_PIN_OUT[7] == $past(SPI_SCK_DRV_IN);
    endproperty
    a_sck_m: assert property (p_sck_m) else $error("clock pin not driven");
    property p_sck_s; s_slv |=> !PE_PIN_OE_OUT[7]; endproperty
    a_sck_s: assert property (p_sck_s) else $error("clock pin driven");
    property p_mosi; s_mst |=> PE_PIN_OE_OUT[6] && PE_PIN_OUT[6] == $past(SPI_MOSI_DRV_IN);
    endproperty
    a_mosi: assert property (p_mosi) else $error("mosi pin wrong");
    property p_miso; s_slv |=> PE_PIN_OE_OUT[5] && PE_PIN_OUT[5] == $past(SPI_MISO_DRV_IN);
    endproperty
    a_miso: assert property (p_miso) else $error("miso pin wrong");
    property p_ss;
        SPI_ENABLE_OUT && !(SPI_MASTER_OUT && !MODE_FAULT_EN_OUT) |=> !PE_PIN_OE_OUT[4];
    endproperty
    a_ss: assert property (p_ss) else $error("select pin driven");
    property p_rxd; SCI_ENABLE_OUT |=> !PE_PIN_OE_OUT[1]; endproperty
    a_rxd: assert property (p_rxd) else $error("receive pin driven");
    property p_txd; SCI_ENABLE_OUT |=> PE_PIN_OE_OUT[0] && PE_PIN_OUT[0] == $past(SCI_TXD_DRV_IN);
    endproperty
    a_txd: assert property (p_txd) else $error("transmit pin wrong");
    property p_tch1; TMR_ELS_OUT[3:2] != 2'b00 |=> PE_PIN_OE_OUT[3] == $past(TMR_CH_OE_IN[1]);
    endproperty
    a_tch1: assert property (p_tch1) else $error("timer pin E3 wrong");
    property p_tchf; TMR_ELS_OUT[5:4] != 2'b00 |=> PF_PIN_OE_OUT[0] == $past(TMR_CH_OE_IN[2])
        && (!PF_PIN_OE_OUT[0] || PF_PIN_OUT[0] == $past(TMR_CH_DRV_IN[2])); endproperty
    a_tchf: assert property (p_tchf) else $error("timer pin F0 wrong");
    property p_rd0;
        !(HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN) |=> HRDATA_OUT == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("read data outside read");
endmodule // sgpef_checker

bind sgpef_top sgpef_checker #(.E_WIDTH(E_WIDTH), .F_WIDTH(F_WIDTH), .T_CHANS(T_CHANS)) u_chk (
    .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .HSEL_IN(HSEL_IN), .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN), .HTRANS_IN(HTRANS_IN), .HRDATA_OUT(HRDATA_OUT),
    .PE_PIN_OUT(PE_PIN_OUT), .PE_PIN_OE_OUT(PE_PIN_OE_OUT), .PF_PIN_OUT(PF_PIN_OUT),
    .PF_PIN_OE_OUT(PF_PIN_OE_OUT), .SPI_SCK_DRV_IN(SPI_SCK_DRV_IN),
    .SPI_MOSI_DRV_IN(SPI_MOSI_DRV_IN), .SPI_MISO_DRV_IN(SPI_MISO_DRV_IN),
    .SCI_TXD_DRV_IN(SCI_TXD_DRV_IN), .SPI_ENABLE_OUT(SPI_ENABLE_OUT),
    .SPI_MASTER_OUT(SPI_MASTER_OUT), .MODE_FAULT_EN_OUT(MODE_FAULT_EN_OUT),
    .SCI_ENABLE_OUT(SCI_ENABLE_OUT), .TMR_CH_DRV_IN(TMR_CH_DRV_IN),
    .TMR_CH_OE_IN(TMR_CH_OE_IN), .TMR_ELS_OUT(TMR_ELS_OUT));

/* File: dv/tb.sv */
/*
 * Self-checking bench of the port E/F block: AHB-Lite register tasks and
 * pin comparisons. Assumes sgpef_pins on both ports and the bound checker.
 */
`timescale 1ns/100ps
`include "sgpef_map.vh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("mismatch %s exp %0h got %0h", nm, ex, got); end end

module tb;
    localparam logic [7:0] A_ED = {`SGPEF_IDX_E_DATA, 2'b00};
    localparam logic [7:0] A_FD = {`SGPEF_IDX_F_DATA, 2'b00};
    localparam logic [7:0] A_EV = {`SGPEF_IDX_E_DIR, 2'b00};
    localparam logic [7:0] A_FV = {`SGPEF_IDX_F_DIR, 2'b00};
    localparam logic [7:0] A_RT = {`SGPEF_IDX_ROUTE, 2'b00};
    localparam logic [7:0] A_TS = {`SGPEF_IDX_TMR_ELS, 2'b00};
    logic        clk, rst, hsel, hwr, sck, mosi, miso, txd;
    logic [7:0]  haddr, pe_ext;
    logic [1:0]  htr;
    logic [31:0] hwd, rd;
    logic [3:0]  pf_ext;
    logic [5:0]  tdrv, toe;
    wire  [31:0] hrd;
    wire         hro, hresp, spi_en, spi_m, modf, sci_en;
    wire  [7:0]  pe_lvl, pe_out, pe_oe;
    wire  [3:0]  pf_lvl, pf_out, pf_oe;
    wire  [11:0] els;
    int          n_fail, checks, cyc;
    logic [3:0]  modes [5] = '{4'h1, 4'h3, 4'h7, 4'h8, 4'h0};

    sgpef_top dut (.REF_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(3'h2), .HWDATA_IN(hwd), .HREADY_IN(hro),
        .HRDATA_OUT(hrd), .HREADYOUT_OUT(hro), .HRESP_OUT(hresp), .PE_PIN_IN(pe_lvl),
        .PE_PIN_OUT(pe_out), .PE_PIN_OE_OUT(pe_oe), .PF_PIN_IN(pf_lvl), .PF_PIN_OUT(pf_out),
        .PF_PIN_OE_OUT(pf_oe), .SPI_SCK_DRV_IN(sck), .SPI_MOSI_DRV_IN(mosi),
        .SPI_MISO_DRV_IN(miso), .SCI_TXD_DRV_IN(txd), .TMR_CH_DRV_IN(tdrv),
        .TMR_CH_OE_IN(toe), .SPI_ENABLE_OUT(spi_en), .SPI_MASTER_OUT(spi_m),
        .MODE_FAULT_EN_OUT(modf), .SCI_ENABLE_OUT(sci_en), .TMR_ELS_OUT(els));
    sgpef_pins #(.W(8)) u_pe (.clk_in({8{clk}}), .pin_in(pe_out), .oe_in(pe_oe),
        .ext_in(pe_ext), .ext_en_in(8'hff), .level_out(pe_lvl));
    sgpef_pins #(.W(4)) u_pf (.clk_in({4{clk}}), .pin_in(pf_out), .oe_in(pf_oe),
        .ext_in(pf_ext), .ext_en_in(4'hf), .level_out(pf_lvl));

    // Clock of 50 ns period
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Single word transfer; the request holds until ready is sampled high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htr <= 2'b10;
        hwr <= w;
        haddr <= a;
        do @(posedge clk); while (hro !== 1'b1);
        hsel <= 1'b0;
        htr <= 2'b00;
        hwd <= d;
        do @(posedge clk); while (hro !== 1'b1);
        rd = hrd;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        bus(1'b0, a, 32'h0);
        `CHK(nm, ex, rd)
    endtask

    // Expected port E enables and driven values for a routing mode, direction all ones
    function automatic logic [15:0] eexp(input logic [3:0] r);
        logic s, m, ss;
        s = r[0];
        m = s & r[1];
        ss = s & ~(r[1] & ~r[2]);
        return {s ? m : 1'b1, s ? m : 1'b1, s ? ~m : 1'b1, ~ss, 2'b11, ~r[3], 1'b1,
                m, m, s & ~m, 4'h0, r[3]};
    endfunction

    task automatic summarize;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cuts a hang short; the whole sequence needs under a hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        {rst, hsel, hwr, htr, haddr, hwd} <= {1'b1, 44'h0};
        {sck, mosi, miso, txd, tdrv, toe} <= 16'h0;
        pe_ext = 8'h5a;
        pf_ext = 4'h3;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rdchk("e_dir_rst", A_EV, 32'h0);
        rdchk("f_dir_rst", A_FV, 32'h0);
        rdchk("route_rst", A_RT, 32'h0);
        rdchk("els_rst", A_TS, 32'h0);
        `CHK("oe_rst", 12'h0, {pe_oe, pf_oe})
        rdchk("e_pin", A_ED, 32'h5a);
        wr(A_ED, 32'hc3);
        rdchk("e_in_write", A_ED, 32'h5a);
        wr(A_EV, 32'h0f);
        rdchk("e_mix", A_ED, 32'h53);
        rdchk("e_dir", A_EV, 32'h0f);
        `CHK("e_drive", 16'h0f03, {pe_oe, pe_out & 8'h0f})
        wr(A_FD, 32'ha);
        wr(A_FV, 32'h6);
        rdchk("f_mix", A_FD, 32'h3);
        rdchk("f_dir", A_FV, 32'h6);
        `CHK("f_drive", 8'h62, {pf_oe, pf_out & 4'h6})
        // Second reset in mid-run: port F latch must survive it
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        wr(A_FV, 32'hf);
        rdchk("f_keep", A_FD, 32'ha);
        wr(A_ED, 32'h00);
        wr(A_EV, 32'hff);
        {sck, mosi, miso, txd} <= 4'hf;
        // Five routing modes (SPI slave, master, master with mode fault, serial, off), with direction bits set to output everywhere
        foreach (modes[i]) begin
            wr(A_RT, {28'h0, modes[i]});
            rdchk("route", A_RT, {28'h0, modes[i]});
            `CHK("route_out", modes[i], {sci_en, modf, spi_m, spi_en})
            `CHK("e_own", eexp(modes[i]), {pe_oe, pe_out & pe_oe})
            rdchk("e_own_rd", A_ED, 32'h0);
        end
        tdrv <= 6'h3f;
        toe <= 6'h24;
        wr(A_TS, 32'hc18);
        rdchk("els", A_TS, 32'hc18);
        `CHK("els_out", 12'hc18, els)
        `CHK("tmr_pins", 16'hf7fb, {pe_oe, pf_oe, pf_out & pf_oe})
        rdchk("f_own_rd", A_FD, 32'ha);
        wr(8'hfc, 32'hff);
        rdchk("unmapped", 8'hfc, 32'h0);
        `CHK("resp", 2'b10, {hro, hresp})
        summarize();
    end
endmodule // tb
